// >>> rtl/jct_tap.v
// Functional notes
// (RL1) Sample inputs on TCK rise, drive TDO on fall
// (RL2) Sixteen-state controller steered by mode-select
// (RL3) Mode-select high five cycles reaches reset state
// (RL4) Reset state exits to idle; idle runs deferred operations
// (RL5) Capture-DR loads selected register into shift path
// (RL6) Capture-IR loads the identification opcode
// (RL7) Pause states hold the shift path
// (RL8) Program, erase, verify start on idle entry
// (RL9) Other instructions act when passing update
// (RL10) Bypass opcode selects one-bit bypass register
// (RL11) All-zero opcode behaves as bypass
// (RL12) Sample/preload opcode selects bypass register
// (RL13) Identification opcode selects 32-bit ID register
// (RL14) ID readable right after reset or power-up
// (RL15) Address-select opcode selects 61-bit address register
// (RL16) Data-select opcode selects 81-bit data register
// (RL17) Signature read loads storage; write stores back
// (RL18) Output-disable opcode tri-states digital outputs
// (RL19) Column program writes; readback reads addressed column
// (RL20) Autoinc init, program and readback advance address
// (RL21) Separate done-bit erase and program opcodes
// (RL22) Decode enable, disable, erase, fuse, discharge, reset
// (RL23) Host enables program mode before programming
// (RL24) Reset state cancels program mode
// (RL25) Output forcing acts after Update-IR
// (RL26) Eight-bit IR, LSB first, updated in Update-IR
// (RL27) Unknown opcodes select bypass
`timescale 1ns/10ps
`default_nettype none
`include "jct_defines.vh"

module jct_tap (
    input wire clk,
    input wire rst_n,
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo,
    output reg tdo_oe,
    output reg output_disable,
    output reg program_mode,
    output reg done_bit,
    output reg security_fuse,
    output reg device_reset,
    output reg supply_discharge,
    output reg [3:0] tap_state
);

    localparam [3:0] ST_TLR = 4'h0;
    localparam [3:0] ST_RTI = 4'h1;
    localparam [3:0] ST_SEL_DR = 4'h2;
    localparam [3:0] ST_CAP_DR = 4'h3;
    localparam [3:0] ST_SH_DR = 4'h4;
    localparam [3:0] ST_EX1_DR = 4'h5;
    localparam [3:0] ST_PA_DR = 4'h6;
    localparam [3:0] ST_EX2_DR = 4'h7;
    localparam [3:0] ST_UPD_DR = 4'h8;
    localparam [3:0] ST_SEL_IR = 4'h9;
    localparam [3:0] ST_CAP_IR = 4'ha;
    localparam [3:0] ST_SH_IR = 4'hb;
    localparam [3:0] ST_EX1_IR = 4'hc;
    localparam [3:0] ST_PA_IR = 4'hd;
    localparam [3:0] ST_EX2_IR = 4'he;
    localparam [3:0] ST_UPD_IR = 4'hf;

    // Pin synchronisers; first stage feeds only the second
    reg [1:0] tck_sync;
    reg [1:0] tms_sync;
    reg [1:0] tdi_sync;
    reg tck_prev;
    wire tck_rise = tck_sync[1] & ~tck_prev; // RL1
    wire tck_fall = ~tck_sync[1] & tck_prev; // RL1
    wire tms_s = tms_sync[1];
    wire tdi_s = tdi_sync[1];

    reg [3:0] state;
    reg [3:0] next_state;
    reg [`JCT_IR_W-1:0] ir_shift;
    reg [`JCT_IR_W-1:0] ir;
    reg [`JCT_DATA_W-1:0] dr_shift;
    reg [`JCT_DATA_W-1:0] next_dr;
    reg [`JCT_ADDR_W-1:0] addr_reg;
    reg [`JCT_DATA_W-1:0] data_reg;
    reg [`JCT_SIG_W-1:0] sig_reg;
    reg [`JCT_SIG_W-1:0] sig_store;
    reg op_armed;
    reg [2:0] sel;
    reg [`JCT_LEN_W-1:0] dr_len;
    reg rti_op;
    reg hiz_op;

    reg [`JCT_DATA_W-1:0] col_mem [0:`JCT_COL_DEPTH-1];
    wire [`JCT_COL_IDX_W-1:0] col_idx = addr_reg[`JCT_COL_IDX_W-1:0];
    // First idle rise after update, once the new opcode is active
    wire run_op = tck_rise && state == ST_RTI && op_armed && rti_op; // RL8
    // Storage-altering operations, except done-bit erase and program, need program mode
    wire prog_ok = program_mode; // RL23
    integer i;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_sync <= 2'h0;
            tms_sync <= 2'h3;
            tdi_sync <= 2'h0;
            tck_prev <= 1'b0;
        end else begin
            tck_sync <= {tck_sync[0], tck};
            tms_sync <= {tms_sync[0], tms};
            tdi_sync <= {tdi_sync[0], tdi};
            tck_prev <= tck_sync[1];
        end
    end

    // Controller next state
    always @* begin
        case (state) // RL2
            ST_TLR: next_state = tms_s ? ST_TLR : ST_RTI; // RL3 RL4
            ST_RTI: next_state = tms_s ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: next_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: next_state = tms_s ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tms_s ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: next_state = tms_s ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_state = tms_s ? ST_UPD_DR : ST_SH_DR; // RL7
            ST_UPD_DR: next_state = tms_s ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: next_state = tms_s ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: next_state = tms_s ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tms_s ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: next_state = tms_s ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_state = tms_s ? ST_UPD_IR : ST_SH_IR; // RL7
            ST_UPD_IR: next_state = tms_s ? ST_SEL_DR : ST_RTI;
            default: next_state = ST_TLR;
        endcase
    end

    // Scan path chosen by the active instruction
    always @* begin
        case (ir)
            `JCT_OP_IDCODE: sel = `JCT_SEL_ID; // RL13
            `JCT_OP_ARRAY_ADDRESS_SELECT: sel = `JCT_SEL_ADDR; // RL15
            `JCT_OP_ARRAY_DATA_SELECT: sel = `JCT_SEL_DATA; // RL16
            `JCT_OP_USER_SIGNATURE_READ: sel = `JCT_SEL_SIG; // RL17
            `JCT_OP_USER_SIGNATURE_WRITE: sel = `JCT_SEL_SIG;
            // Bypass, extest, sample, non-scan operation and unknown codes
            default: sel = `JCT_SEL_BYPASS; // RL10 RL11 RL12 RL27
        endcase
        case (sel)
            `JCT_SEL_ID: dr_len = `JCT_ID_LEN;
            `JCT_SEL_ADDR: dr_len = `JCT_ADDR_LEN;
            `JCT_SEL_DATA: dr_len = `JCT_DATA_LEN;
            `JCT_SEL_SIG: dr_len = `JCT_SIG_LEN;
            default: dr_len = `JCT_BYP_LEN;
        endcase
    end

    // Operations deferred to the next idle entry, and opcodes that disable outputs
    always @* begin
        case (ir)
            `JCT_OP_BULK_ERASE,
            `JCT_OP_ARRAY_COLUMN_PROGRAM,
            `JCT_OP_ARRAY_PROGRAM_AUTOINC,
            `JCT_OP_ARRAY_COLUMN_READBACK,
            `JCT_OP_ARRAY_READBACK_AUTOINC,
            `JCT_OP_USER_SIGNATURE_WRITE,
            `JCT_OP_SECURITY_FUSE_PROGRAM,
            `JCT_OP_DONE_ERASE,
            `JCT_OP_DONE_PROGRAM: rti_op = 1'b1; // RL8
            default: rti_op = 1'b0;
        endcase
        case (ir)
            `JCT_OP_OUTPUT_DISABLE,
            `JCT_OP_ARRAY_ADDRESS_SELECT,
            `JCT_OP_ARRAY_DATA_SELECT,
            `JCT_OP_ARRAY_COLUMN_PROGRAM,
            `JCT_OP_ARRAY_COLUMN_READBACK,
            `JCT_OP_SECURITY_FUSE_PROGRAM,
            `JCT_OP_SUPPLY_DISCHARGE,
            `JCT_OP_BULK_ERASE,
            `JCT_OP_PROGRAM_ENABLE,
            `JCT_OP_USER_SIGNATURE_WRITE: hiz_op = 1'b1; // RL18
            default: hiz_op = 1'b0;
        endcase
    end

    // Serial shift of the selected data path, entering at its top bit
    always @* begin
        next_dr = dr_shift >> 1;
        next_dr[dr_len-7'h01] = tdi_s;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_TLR; // RL3
        end else if (tck_rise) begin
            state <= next_state; // RL2
        end
    end

    // Instruction register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift <= `JCT_IR_RESET;
            ir <= `JCT_IR_RESET; // RL14
        end else if (tck_rise) begin
            case (state)
                ST_TLR: ir <= `JCT_OP_IDCODE; // RL14
                ST_CAP_IR: ir_shift <= `JCT_OP_IDCODE; // RL6
                ST_SH_IR: ir_shift <= {tdi_s, ir_shift[7:1]}; // RL26
                ST_UPD_IR: ir <= ir_shift; // RL26 RL9
                default: ir_shift <= ir_shift;
            endcase
        end
    end

    // Data shift path and the registers behind it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dr_shift <= {`JCT_DATA_W{1'b0}};
            addr_reg <= {`JCT_ADDR_W{1'b0}};
            data_reg <= {`JCT_DATA_W{1'b0}};
            sig_reg <= {`JCT_SIG_W{1'b0}};
        end else if (tck_rise) begin
            if (state == ST_CAP_DR) begin
                case (sel) // RL5
                    `JCT_SEL_ID:
                        dr_shift <= {49'h0, `JCT_IDCODE_VALUE}; // RL13
                    `JCT_SEL_ADDR: dr_shift <= {20'h0, addr_reg};
                    `JCT_SEL_DATA: dr_shift <= data_reg;
                    `JCT_SEL_SIG: begin
                        if (ir == `JCT_OP_USER_SIGNATURE_READ) begin
                            dr_shift <= {49'h0, sig_store}; // RL17
                        end else begin
                            dr_shift <= {49'h0, sig_reg};
                        end
                    end
                    default: dr_shift <= {`JCT_DATA_W{1'b0}};
                endcase
            end else if (state == ST_SH_DR) begin
                dr_shift <= next_dr;
            end
            // Pause and exit states leave the path as is (RL7)
            if (state == ST_UPD_DR) begin
                case (sel)
                    `JCT_SEL_ADDR:
                        addr_reg <= dr_shift[`JCT_ADDR_W-1:0]; // RL15
                    `JCT_SEL_DATA: data_reg <= dr_shift; // RL16
                    `JCT_SEL_SIG: sig_reg <= dr_shift[`JCT_SIG_W-1:0];
                    default: sig_reg <= sig_reg;
                endcase
            end
            if (state == ST_UPD_IR && ir_shift ==
                    `JCT_OP_ARRAY_ADDRESS_AUTOINC_INIT) begin
                addr_reg <= {`JCT_ADDR_W{1'b0}}; // RL20
            end
            if (run_op) begin
                case (ir)
                    `JCT_OP_ARRAY_COLUMN_READBACK:
                        data_reg <= security_fuse ?
                            {`JCT_DATA_W{1'b0}} : col_mem[col_idx]; // RL19
                    `JCT_OP_ARRAY_READBACK_AUTOINC: begin
                        data_reg <= security_fuse ?
                            {`JCT_DATA_W{1'b0}} : col_mem[col_idx];
                        addr_reg <= addr_reg + 61'h1; // RL20
                    end
                    `JCT_OP_ARRAY_PROGRAM_AUTOINC: begin
                        if (prog_ok) begin
                            addr_reg <= addr_reg + 61'h1; // RL20
                        end
                    end
                    default: data_reg <= data_reg;
                endcase
            end
        end
    end

    // Column storage; bulk erase clears every column
    always @(posedge clk) begin
        if (tck_rise && run_op && prog_ok) begin
            case (ir)
                `JCT_OP_ARRAY_COLUMN_PROGRAM,
                `JCT_OP_ARRAY_PROGRAM_AUTOINC:
                    col_mem[col_idx] <= data_reg; // RL19 RL20
                `JCT_OP_BULK_ERASE: begin
                    for (i = 0; i < `JCT_COL_DEPTH; i = i + 1) begin
                        col_mem[i] <= {`JCT_DATA_W{1'b0}}; // RL22
                    end
                end
                default: col_mem[col_idx] <= col_mem[col_idx];
            endcase
        end
    end

    // Mode bits, non-volatile flags and command pulses
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_mode <= 1'b0;
            done_bit <= 1'b0;
            security_fuse <= 1'b0;
            sig_store <= {`JCT_SIG_W{1'b0}};
            op_armed <= 1'b0;
            device_reset <= 1'b0;
            supply_discharge <= 1'b0;
        end else begin
            device_reset <= 1'b0;
            supply_discharge <= 1'b0;
            if (tck_rise || state == ST_TLR) begin
                if (state == ST_TLR) begin
                    program_mode <= 1'b0; // RL24
                    op_armed <= 1'b0;
                end else if (state == ST_UPD_IR) begin
                    op_armed <= 1'b1; // RL8
                    case (ir_shift) // RL9 RL22
                        `JCT_OP_PROGRAM_ENABLE: program_mode <= 1'b1;
                        `JCT_OP_PROGRAM_DISABLE: program_mode <= 1'b0;
                        `JCT_OP_DEVICE_RESET: device_reset <= 1'b1;
                        `JCT_OP_SUPPLY_DISCHARGE: supply_discharge <= 1'b1;
                        default: op_armed <= 1'b1;
                    endcase
                end else if (run_op) begin
                    op_armed <= 1'b0;
                    case (ir)
                        `JCT_OP_DONE_ERASE: done_bit <= 1'b0; // RL21
                        `JCT_OP_DONE_PROGRAM: done_bit <= 1'b1; // RL21
                        `JCT_OP_SECURITY_FUSE_PROGRAM:
                            security_fuse <= security_fuse | prog_ok;
                        `JCT_OP_USER_SIGNATURE_WRITE: begin
                            if (prog_ok) begin
                                sig_store <= sig_reg; // RL17
                            end
                        end
                        `JCT_OP_BULK_ERASE: begin
                            if (prog_ok) begin
                                sig_store <= {`JCT_SIG_W{1'b0}}; // RL22
                                security_fuse <= 1'b0;
                                done_bit <= 1'b0;
                            end
                        end
                        default: op_armed <= 1'b0;
                    endcase
                end
            end
        end
    end

    // TDO on the falling edge; enabled only while shifting
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= (state == ST_SH_DR) || (state == ST_SH_IR); // RL1
            tdo <= (state == ST_SH_IR) ? ir_shift[0] : dr_shift[0]; // RL1
        end
    end

    // Forcing follows the active instruction, so it starts after Update-IR
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_disable <= 1'b0;
            tap_state <= ST_TLR;
        end else begin
            output_disable <= hiz_op; // RL18 RL25
            tap_state <= state;
        end
    end

endmodule
`default_nettype wire

// >>> common/jct_defines.vh
`ifndef JCT_DEFINES_VH
`define JCT_DEFINES_VH

// Instruction register
`define JCT_IR_W 8
`define JCT_IR_RESET 8'h16

// Opcodes
`define JCT_OP_EXTEST 8'h00
`define JCT_OP_ARRAY_ADDRESS_SELECT 8'h01
`define JCT_OP_ARRAY_DATA_SELECT 8'h02
`define JCT_OP_BULK_ERASE 8'h03
`define JCT_OP_ARRAY_COLUMN_PROGRAM 8'h07
`define JCT_OP_SECURITY_FUSE_PROGRAM 8'h09
`define JCT_OP_ARRAY_COLUMN_READBACK 8'h0a
`define JCT_OP_SUPPLY_DISCHARGE 8'h14
`define JCT_OP_PROGRAM_ENABLE 8'h15
`define JCT_OP_IDCODE 8'h16
`define JCT_OP_USER_SIGNATURE_READ 8'h17
`define JCT_OP_OUTPUT_DISABLE 8'h18
`define JCT_OP_USER_SIGNATURE_WRITE 8'h1a
`define JCT_OP_SAMPLE_PRELOAD 8'h1c
`define JCT_OP_PROGRAM_DISABLE 8'h1e
`define JCT_OP_ARRAY_ADDRESS_AUTOINC_INIT 8'h21
`define JCT_OP_DEVICE_RESET 8'h22
`define JCT_OP_DONE_ERASE 8'h24
`define JCT_OP_ARRAY_PROGRAM_AUTOINC 8'h27
`define JCT_OP_ARRAY_READBACK_AUTOINC 8'h2a
`define JCT_OP_DONE_PROGRAM 8'h2f
`define JCT_OP_BYPASS 8'hff

// Data register lengths
`define JCT_ID_W 32
`define JCT_ADDR_W 61
`define JCT_DATA_W 81
`define JCT_SIG_W 32
`define JCT_LEN_W 7
`define JCT_ID_LEN 7'h20
`define JCT_ADDR_LEN 7'h3d
`define JCT_DATA_LEN 7'h51
`define JCT_SIG_LEN 7'h20
`define JCT_BYP_LEN 7'h01

// Modelled column storage
`define JCT_COL_IDX_W 4
`define JCT_COL_DEPTH 16

// Scan path selection
`define JCT_SEL_BYPASS 3'h0
`define JCT_SEL_ID 3'h1
`define JCT_SEL_ADDR 3'h2
`define JCT_SEL_DATA 3'h3
`define JCT_SEL_SIG 3'h4

// Identification value, arbitrary
`define JCT_IDCODE_VALUE 32'h0a5c3001

`endif

// >>> sim/jct_tap_checker.sv
`timescale 1ns/10ps
`default_nettype none
module jct_tap_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic output_disable,
    input wire logic program_mode,
    input wire logic done_bit,
    input wire logic security_fuse,
    input wire logic device_reset,
    input wire logic supply_discharge,
    input wire logic [3:0] tap_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_tlr_exit_idle: assert property (
        (tap_state == 4'h0) ##1 (tap_state != 4'h0) |-> tap_state == 4'h1)
        else $error("reset state left to a wrong state");
    a_shift_dr_entry: assert property (
        $changed(tap_state) && tap_state == 4'h4
        |-> $past(tap_state) == 4'h3 || $past(tap_state) == 4'h7)
        else $error("shift-dr entered from a wrong state");
    a_pause_exit: assert property (
        $past(tap_state) == 4'h6 && tap_state != 4'h6 |-> tap_state == 4'h7)
        else $error("pause-dr left to a wrong state");
    // Capture sees a one-cycle lag on the state output
    a_tdo_on_fall: assert property (
        $changed(tdo) |-> !$past(tck, 1) && !$past(tck, 2))
        else $error("serial output moved while test clock high");
    a_oe_in_shift: assert property (
        $rose(tdo_oe) |-> tap_state == 4'h4 || tap_state == 4'hb)
        else $error("serial output enabled outside shift");
    a_pulse_at_update: assert property (
        device_reset || supply_discharge
        |-> (tap_state inside {4'hf, 4'h1, 4'h2})
        ##1 !(device_reset || supply_discharge))
        else $error("action pulse misplaced or too long");
    a_odis_update: assert property (
        $changed(output_disable) |-> tap_state inside {4'h0, 4'h1, 4'h2})
        else $error("output disable moved away from update");
    a_done_at_idle: assert property (
        $changed(done_bit) |-> tap_state == 4'hf || tap_state == 4'h1)
        else $error("done bit moved away from idle entry");
    a_pmode_cancel: assert property (
        tap_state == 4'h0 |-> ##[0:1] !program_mode)
        else $error("program mode kept through reset state");

    c_shift_dr: cover property (tap_state == 4'h4);
    c_pause_dr: cover property (tap_state == 4'h6);
    c_pmode_on: cover property ($rose(program_mode));
    c_dev_reset: cover property (device_reset);
endmodule
bind jct_tap jct_tap_checker u_chk (.clk(clk), .rst_n(rst_n), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .output_disable(output_disable), .program_mode(program_mode),
    .done_bit(done_bit), .security_fuse(security_fuse),
    .device_reset(device_reset), .supply_discharge(supply_discharge),
    .tap_state(tap_state));
`default_nettype wire

// >>> sim/jct_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module jct_host_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // Clock parks low between frames; control steps toggle tdi
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #200;
        tck = 1'b1;
        q = tdo;
        #200;
        tck = 1'b0;
    endtask

    task automatic idle(input int n);
        logic q;
        repeat (n) step(1'b0, ~tdi, q);
    endtask

    task automatic tlr();
        logic q;
        repeat (5) step(1'b1, ~tdi, q);
    endtask

    task automatic ir_scan(input logic [7:0] op, output logic [7:0] cap);
        logic q;
        step(1'b1, ~tdi, q);
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < 8; i++) begin
            step(i == 7, op[i], q);
            cap[i] = q;
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask

    task automatic dr_scan(input int n, input logic [127:0] din,
                           input int pa, output logic [127:0] dout);
        logic q;
        dout = '0;
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1 || i == pa - 1, din[i], q);
            dout[i] = q;
            if (i == pa - 1 && i != n - 1) begin
                idle(2);
                step(1'b1, ~tdi, q);
                step(1'b0, ~tdi, q);
            end
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_jtag_config_tap.sv
`timescale 1ns/10ps
`default_nettype none
`include "jct_defines.vh"
module tb_jtag_config_tap;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe, output_disable, program_mode;
    logic done_bit, security_fuse, device_reset, supply_discharge;
    logic [3:0] tap_state;
    logic [7:0] cap;
    logic [127:0] din, dout, col;
    logic [7:0] ops [8];
    int lens [8];
    int fails = 0;
    int tests_run = 0;
    int n_rst = 0;
    int n_dis = 0;
    int seed_ret;

    always #25 clk = ~clk;

    jct_tap uut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .output_disable(output_disable), .program_mode(program_mode),
        .done_bit(done_bit), .security_fuse(security_fuse),
        .device_reset(device_reset), .supply_discharge(supply_discharge),
        .tap_state(tap_state));
    jct_host_model host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    always @(posedge clk) begin
        if (device_reset === 1'b1) n_rst <= n_rst + 1;
        if (supply_discharge === 1'b1) n_dis <= n_dis + 1;
    end

    function automatic logic [127:0] rnd();
        return {$urandom, $urandom, $urandom, $urandom};
    endfunction

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %0h want %0h",
                $time, got, exp);
        end
    endtask

    // Idle steps give deferred operations their idle entry
    task automatic ir(input logic [7:0] op);
        host.ir_scan(op, cap);
        chk(cap, `JCT_IR_RESET);
        host.idle(2);
        repeat (10) @(negedge clk);
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #3000000;
        fails++;
        tally_and_finish();
    end

    initial begin
        seed_ret = $urandom(32'ha994);
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(tap_state, 4'h0);
        host.idle(1);
        host.dr_scan(32, rnd(), 13, dout);
        chk(dout[31:0], `JCT_IDCODE_VALUE);
        ops = '{`JCT_OP_BYPASS, `JCT_OP_EXTEST, `JCT_OP_SAMPLE_PRELOAD, 8'h80,
            `JCT_OP_IDCODE, `JCT_OP_ARRAY_ADDRESS_SELECT,
            `JCT_OP_ARRAY_DATA_SELECT, `JCT_OP_USER_SIGNATURE_READ};
        ops[3] = 8'h80 | 8'($urandom & 32'h7e);
        lens = '{1, 1, 1, 1, `JCT_ID_W, `JCT_ADDR_W, `JCT_DATA_W, `JCT_SIG_W};
        for (int i = 0; i < 8; i++) begin
            ir(ops[i]);
            din = rnd();
            host.dr_scan(lens[i] + 8, din, 0, dout);
            dout = dout >> lens[i];
            chk(dout[7:0], din[7:0]);
        end
        ir(`JCT_OP_SECURITY_FUSE_PROGRAM);
        chk(security_fuse, 1'b0);
        ir(`JCT_OP_PROGRAM_ENABLE);
        chk(program_mode, 1'b1);
        chk(output_disable, 1'b1);
        ir(`JCT_OP_ARRAY_ADDRESS_SELECT);
        host.dr_scan(`JCT_ADDR_W, rnd(), 0, dout);
        ir(`JCT_OP_ARRAY_DATA_SELECT);
        col = rnd();
        host.dr_scan(`JCT_DATA_W, col, 0, dout);
        ir(`JCT_OP_ARRAY_COLUMN_PROGRAM);
        ir(`JCT_OP_ARRAY_DATA_SELECT);
        host.dr_scan(`JCT_DATA_W, 128'h0, 0, dout);
        ir(`JCT_OP_ARRAY_COLUMN_READBACK);
        ir(`JCT_OP_ARRAY_DATA_SELECT);
        host.dr_scan(`JCT_DATA_W, 128'h0, 0, dout);
        chk(dout[80:0], col[80:0]);
        ir(`JCT_OP_ARRAY_ADDRESS_AUTOINC_INIT);
        ir(`JCT_OP_ARRAY_ADDRESS_SELECT);
        host.dr_scan(`JCT_ADDR_W, 128'h0, 0, dout);
        chk(dout[60:0], 61'h0);
        ir(`JCT_OP_ARRAY_READBACK_AUTOINC);
        ir(`JCT_OP_ARRAY_ADDRESS_SELECT);
        host.dr_scan(`JCT_ADDR_W, 128'h0, 0, dout);
        chk(dout[60:0], 61'h1);
        ir(`JCT_OP_DONE_PROGRAM);
        chk(done_bit, 1'b1);
        ir(`JCT_OP_DONE_ERASE);
        chk(done_bit, 1'b0);
        ir(`JCT_OP_DEVICE_RESET);
        ir(`JCT_OP_SUPPLY_DISCHARGE);
        chk({n_rst[7:0], n_dis[7:0]}, 16'h0101);
        ir(`JCT_OP_IDCODE);
        chk(output_disable, 1'b0);
        ir(`JCT_OP_OUTPUT_DISABLE);
        chk(output_disable, 1'b1);
        ir(`JCT_OP_SECURITY_FUSE_PROGRAM);
        chk(security_fuse, 1'b1);
        ir(`JCT_OP_ARRAY_DATA_SELECT);
        host.dr_scan(`JCT_DATA_W, col, 0, dout);
        ir(`JCT_OP_ARRAY_COLUMN_READBACK);
        ir(`JCT_OP_ARRAY_DATA_SELECT);
        host.dr_scan(`JCT_DATA_W, 128'h0, 0, dout);
        chk(dout[80:0], 81'h0);
        host.tlr();
        repeat (10) @(negedge clk);
        chk({tap_state, program_mode}, 5'h00);
        host.idle(1);
        host.dr_scan(32, rnd(), 0, dout);
        chk(dout[31:0], `JCT_IDCODE_VALUE);
        tally_and_finish();
    end
endmodule
`default_nettype wire
